// ---- inc/aboe_map.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  accumulator execute block. Assumes inclusion by bare name from src/.
*/
`ifndef ABOE_MAP_SVH
`define ABOE_MAP_SVH

// timing: core clock period and instruction cycle length
`define ABOE_CLK_NS 10
`define ABOE_TCY_NS 40
`define ABOE_TCY_CLKS ((`ABOE_TCY_NS + `ABOE_CLK_NS - 1) / `ABOE_CLK_NS)

// register byte offsets
`define ABOE_OFS_INSN 8'h00
`define ABOE_OFS_ACC 8'h04
`define ABOE_OFS_STATUS 8'h08
`define ABOE_OFS_FPTR 8'h0c
`define ABOE_OFS_FDATA 8'h10
`define ABOE_OFS_CYCLES 8'h14

// instruction word fields
`define ABOE_INSN_OP_LSB 0
`define ABOE_INSN_DEST_POS 4
`define ABOE_INSN_BIT_LSB 5
`define ABOE_INSN_FILE_LSB 8
`define ABOE_INSN_IMM_LSB 16

// status word fields
`define ABOE_STAT_CARRY 0
`define ABOE_STAT_NIBBLE 1
`define ABOE_STAT_ZERO 2
`define ABOE_STAT_PEND 3
`define ABOE_STAT_SKIP 4
`define ABOE_STAT_DISC 5

// destination select and bus responses
`define ABOE_DEST_ACC 1'b0
`define ABOE_DEST_FILE 1'b1
`define ABOE_RESP_OKAY 2'b00
`define ABOE_RESP_SLVERR 2'b10

// reset values and the file address of the i/o port
`define ABOE_ACC_RST 8'h00
`define ABOE_PORT_RST 8'h00
`define ABOE_PORT_ADDR 7'h05

`endif

// ---- inc/aboe_pkg.sv ----
/*
  Types for the accumulator execute block: the operation selector.
  Assumes nothing of its surroundings.
*/
package aboe_pkg;

  // operations; codes outside this list execute as an idle slot
  typedef enum logic [3:0] {
    idle_slot,
    sum_immediate_into_acc,
    sum_acc_with_register,
    mask_acc_with_immediate,
    mask_acc_with_register,
    single_bit_clear,
    single_bit_raise,
    test_skip_when_one,
    test_skip_when_zero
  } aboe_op_type;

endpackage

// ---- sim/test_add_and_bit_ops_execute.sv ----
/*
  Self-checking bench for the accumulator execute block over AXI4-Lite.
  Assumes the register map of aboe_map.svh and the op codes of aboe_pkg.
*/
`timescale 1ns/10ps
module test_add_and_bit_ops_execute;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, pins = 8'h3c;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wr, bv, arr, rv, busy;
  logic [1:0] br, rr;
  logic [7:0] acc, latch;
  int n_errors = 0, checks = 0, cyc = 0;

  aboe_top aboe_top_inst (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .AXI_AWVALID_IN(awv),
    .AXI_AWREADY_OUT(awr), .AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bry),
    .AXI_BRESP_OUT(br), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr), .AXI_ARADDR_IN(ara),
    .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rry), .AXI_RDATA_OUT(rdat), .AXI_RRESP_OUT(rr),
    .PORT_PINS_IN(pins), .PORT_LATCH_OUT(latch), .ACC_OUT(acc), .BUSY_OUT(busy));

  always #5 clk = ~clk;

  // watchdog: a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task complete_run;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one write; the leading edge keeps two calls from driving a signal twice at once
  task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wn;
    ad = 1'b0;
    wn = 1'b0;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    while (!(ad && wn)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin ad = 1'b1; awv <= 1'b0; end
      if (!wn && wr === 1'b1) begin wn = 1'b1; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    bry <= 1'b0;
    cmp(br, er);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    rry <= 1'b0;
    cmp(rr, er);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rdr(a, d, 2'b00);
    cmp(d & m, e);
  endtask

  task automatic fw(input logic [6:0] f, input logic [7:0] v);
    bw(8'h0c, {25'h0, f}, 2'b00);
    bw(8'h10, {24'h0, v}, 2'b00);
  endtask

  task automatic fr(input logic [6:0] f, input logic [7:0] e);
    bw(8'h0c, {25'h0, f}, 2'b00);
    rc(8'h10, 32'hff, {24'h0, e});
  endtask

  // issue one instruction and wait until it has executed
  task automatic ex(input aboe_pkg::aboe_op_type op, input logic dst, input logic [2:0] b,
                    input logic [6:0] f, input logic [7:0] k);
    bw(8'h00, {8'h00, k, 1'b0, f, b, dst, op}, 2'b00);
    do @(posedge clk); while (busy !== 1'b0);
  endtask

  task t_sum_imm;
    bw(8'h04, 32'hf8, 2'b00);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'h08);
    cmp(acc, 8'h00);
    rc(8'h08, 32'h7, 32'h7);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'hff);
    cmp(acc, 8'hff);
    rc(8'h08, 32'h7, 32'h0);
  endtask

  task t_sum_reg;
    fw(7'h7f, 8'h0f);
    bw(8'h04, 32'hf1, 2'b00);
    ex(aboe_pkg::sum_acc_with_register, 1'b1, 3'h0, 7'h7f, 8'h00);
    cmp(acc, 8'hf1);
    fr(7'h7f, 8'h00);
    rc(8'h08, 32'h7, 32'h7);
    fw(7'h7f, 8'h0e);
    ex(aboe_pkg::sum_acc_with_register, 1'b0, 3'h0, 7'h7f, 8'h00);
    cmp(acc, 8'hff);
    fr(7'h7f, 8'h0e);
  endtask

  // carry and nibble flags are preset so that a stray update shows
  task t_mask;
    bw(8'h08, 32'h3, 2'b00);
    bw(8'h04, 32'hf0, 2'b00);
    ex(aboe_pkg::mask_acc_with_immediate, 1'b0, 3'h0, 7'h00, 8'h0f);
    cmp(acc, 8'h00);
    rc(8'h08, 32'h7, 32'h7);
    fw(7'h7f, 8'h3c);
    bw(8'h04, 32'h35, 2'b00);
    ex(aboe_pkg::mask_acc_with_register, 1'b1, 3'h0, 7'h7f, 8'h00);
    fr(7'h7f, 8'h34);
    rc(8'h08, 32'h7, 32'h3);
    ex(aboe_pkg::mask_acc_with_register, 1'b0, 3'h0, 7'h7f, 8'h00);
    cmp(acc, 8'h34);
  endtask

  task t_bits;
    bw(8'h08, 32'h5, 2'b00);
    fw(7'h00, 8'ha5);
    ex(aboe_pkg::single_bit_clear, 1'b0, 3'h0, 7'h00, 8'h00);
    ex(aboe_pkg::single_bit_raise, 1'b0, 3'h6, 7'h00, 8'h00);
    fr(7'h00, 8'he4);
    rc(8'h08, 32'h7, 32'h5);
  endtask

  // file 0 holds e4: bit 2 is one, bit 0 is zero
  task t_skip;
    logic [31:0] c0, c1;
    bw(8'h04, 32'h10, 2'b00);
    rdr(8'h14, c0, 2'b00);
    ex(aboe_pkg::test_skip_when_one, 1'b0, 3'h2, 7'h00, 8'h00);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'h01);
    rdr(8'h14, c1, 2'b00);
    cmp(acc, 8'h10);
    cmp(c1, c0 + 32'h2);
    rc(8'h08, 32'h20, 32'h20);
    ex(aboe_pkg::test_skip_when_one, 1'b0, 3'h0, 7'h00, 8'h00);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'h01);
    cmp(acc, 8'h11);
    ex(aboe_pkg::test_skip_when_zero, 1'b0, 3'h0, 7'h00, 8'h00);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'h01);
    cmp(acc, 8'h11);
    ex(aboe_pkg::test_skip_when_zero, 1'b0, 3'h2, 7'h00, 8'h00);
    ex(aboe_pkg::sum_immediate_into_acc, 1'b0, 3'h0, 7'h00, 8'h01);
    cmp(acc, 8'h12);
  endtask

  // latch all ones, pins 3c: a latch-based read would give fe
  task t_port;
    logic [31:0] d;
    fw(7'h05, 8'hff);
    cmp(latch, 8'hff);
    ex(aboe_pkg::single_bit_clear, 1'b0, 3'h0, 7'h05, 8'h00);
    cmp(latch, 8'h3c);
    bw(8'h04, 32'h01, 2'b00);
    ex(aboe_pkg::sum_acc_with_register, 1'b0, 3'h0, 7'h05, 8'h00);
    cmp(acc, 8'h3d);
    rdr(8'h20, d, 2'b10);
    cmp(d, 32'h0);
    bw(8'h14, 32'h0, 2'b10);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_sum_imm();
    t_sum_reg();
    t_mask();
    t_bits();
    t_skip();
    t_port();
    complete_run();
  end
endmodule // test_add_and_bit_ops_execute

// ---- src/aboe_alu.sv ----
/*
  Combinational operation unit: result, flags and write enables for one
  instruction. Assumes operands are stable while the caller samples it.
*/
`timescale 1ns/10ps
`include "aboe_map.svh"

module aboe_alu (
  // operation and operands
  input wire aboe_pkg::aboe_op_type op_in,
  input wire logic dest_in,
  input wire logic [2:0] bit_in,
  input wire logic [7:0] imm_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] file_in,
  // results
  output logic [7:0] result_out,
  output logic carry_out,
  output logic nibble_out,
  output logic zero_out,
  output logic acc_we_out,
  output logic file_we_out,
  output logic [2:0] flag_we_out,
  output logic skip_out
);

  // literal forms take the immediate, register forms the file operand
  wire logic use_imm;
  wire logic [7:0] operand;
  wire logic [8:0] sum9;
  wire logic [4:0] sum5;
  wire logic [7:0] bit_mask;
  assign use_imm = (op_in == aboe_pkg::sum_immediate_into_acc) ||
                   (op_in == aboe_pkg::mask_acc_with_immediate);
  assign operand = use_imm ? imm_in : file_in;
  assign sum9 = {1'b0, acc_in} + {1'b0, operand};
  assign sum5 = {1'b0, acc_in[3:0]} + {1'b0, operand[3:0]};
  assign bit_mask = 8'h01 << bit_in;

  // flags come from the truncated result and the two carry taps
  assign carry_out = sum9[8];
  assign nibble_out = sum5[4];
  assign zero_out = (result_out == 8'h00);

  // per-operation selection of result, target and flag updates
  always_comb begin
    result_out = acc_in;
    acc_we_out = 1'b0;
    file_we_out = 1'b0;
    flag_we_out = 3'b000;
    skip_out = 1'b0;
    unique case (op_in)
      aboe_pkg::sum_immediate_into_acc: begin
        result_out = sum9[7:0];
        acc_we_out = 1'b1;
        flag_we_out = 3'b111;
      end
      aboe_pkg::sum_acc_with_register: begin
        result_out = sum9[7:0];
        acc_we_out = (dest_in == `ABOE_DEST_ACC);
        file_we_out = (dest_in == `ABOE_DEST_FILE);
        flag_we_out = 3'b111;
      end
      aboe_pkg::mask_acc_with_immediate: begin
        result_out = acc_in & imm_in;
        acc_we_out = 1'b1;
        flag_we_out = 3'b100; // zero only
      end
      aboe_pkg::mask_acc_with_register: begin
        result_out = acc_in & file_in;
        acc_we_out = (dest_in == `ABOE_DEST_ACC);
        file_we_out = (dest_in == `ABOE_DEST_FILE);
        flag_we_out = 3'b100;
      end
      aboe_pkg::single_bit_clear: begin
        result_out = file_in & ~bit_mask;
        file_we_out = 1'b1;
      end
      aboe_pkg::single_bit_raise: begin
        result_out = file_in | bit_mask;
        file_we_out = 1'b1;
      end
      aboe_pkg::test_skip_when_one: skip_out = file_in[bit_in];
      aboe_pkg::test_skip_when_zero: skip_out = ~file_in[bit_in];
      aboe_pkg::idle_slot: skip_out = 1'b0;
      default: skip_out = 1'b0; // undefined codes do nothing
    endcase
  end

endmodule // aboe_alu

// ---- src/aboe_regfile.sv ----
/*
  File register array with a separate port latch. Assumes pins_in is
  already synchronised to clk_in.
*/
`timescale 1ns/10ps
`include "aboe_map.svh"

module aboe_regfile #(
  parameter int DEPTH = 128,
  parameter int AW = 7,
  parameter logic [AW-1:0] PORT_ADDR = `ABOE_PORT_ADDR
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // read ports and pins
  input wire logic [AW-1:0] exec_addr_in,
  input wire logic [AW-1:0] sw_addr_in,
  input wire logic [7:0] pins_in,
  output logic [7:0] exec_data_out,
  output logic [7:0] sw_data_out,
  output logic [7:0] latch_out
);

  logic [7:0] mem [DEPTH];
  logic [7:0] latch_reg;

  // the port latch has a reset so the pins never see an unknown value
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_reg <= `ABOE_PORT_RST;
    end else if (we_in && waddr_in == PORT_ADDR) begin
      latch_reg <= wdata_in;
    end
  end

  // plain storage, no reset: software initialises what it uses
  always_ff @(posedge clk_in) begin
    if (we_in && waddr_in != PORT_ADDR) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // execution reads the pin levels at the port address, not the latch
  assign exec_data_out = (exec_addr_in == PORT_ADDR) ? pins_in : mem[exec_addr_in];
  assign sw_data_out = (sw_addr_in == PORT_ADDR) ? latch_reg : mem[sw_addr_in];
  assign latch_out = latch_reg;

endmodule // aboe_regfile

// ---- src/aboe_top.sv ----
/*
  Accumulator execute block with an AXI4-Lite register slave.
  Assumes a single AXI4-Lite master on CORE_CLK_IN and asynchronous pins.
*/
`timescale 1ns/10ps
`include "aboe_map.svh"

module aboe_top #(
  parameter int TCY_CLKS = `ABOE_TCY_CLKS,
  parameter logic [6:0] PORT_ADDR = `ABOE_PORT_ADDR
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  // axi4-lite write address and data
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [7:0] AXI_AWADDR_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  // axi4-lite write response
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  output logic [1:0] AXI_BRESP_OUT,
  // axi4-lite read
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  input wire logic [7:0] AXI_ARADDR_IN,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  // i/o port
  input wire logic [7:0] PORT_PINS_IN,
  output logic [7:0] PORT_LATCH_OUT,
  // core state
  output logic [7:0] ACC_OUT,
  output logic BUSY_OUT
);

  // merge write data into the old word under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = strb[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
    end
    return m;
  endfunction

  // word decode shared by both directions; the map is contiguous from zero
  function automatic logic is_mapped(input logic [7:0] a);
    return {a[7:2], 2'b00} <= `ABOE_OFS_CYCLES;
  endfunction
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return {a[7:2], 2'b00} == ofs;
  endfunction

  // state
  logic [7:0] tcnt_reg, pin_meta_reg, pin_sync_reg, imm_reg, acc_reg, aw_addr_reg;
  logic tick_reg, dest_reg, pending_reg, skip_armed_reg, discard_reg;
  logic carry_reg, nibble_reg, zero_reg, aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [3:0] op_raw_reg, w_strb_reg;
  logic [2:0] bit_reg;
  logic [6:0] faddr_reg, fptr_reg;
  logic [31:0] cycles_reg, w_data_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // operation unit and file wiring
  wire aboe_pkg::aboe_op_type op_cur;
  wire logic [7:0] file_a, file_b;
  logic [7:0] alu_result;
  logic alu_carry, alu_nibble, alu_zero, alu_acc_we, alu_file_we, alu_skip;
  logic [2:0] alu_flag_we;
  assign op_cur = aboe_pkg::aboe_op_type'(op_raw_reg);
  // execution happens once per instruction cycle while work is pending
  wire logic exec, do_op;
  assign exec = tick_reg && pending_reg;
  assign do_op = exec && !skip_armed_reg;
  // register words for read and strobe merge
  wire logic [31:0] insn_word, stat_word;
  assign insn_word = {8'h00, imm_reg, 1'b0, faddr_reg, bit_reg, dest_reg, op_raw_reg};
  assign stat_word = {26'h0, discard_reg, skip_armed_reg, pending_reg,
                      zero_reg, nibble_reg, carry_reg};

  function automatic logic [31:0] word_at(input logic [7:0] a, input logic [31:0] iw,
                                          input logic [31:0] sw, input logic [7:0] acc,
                                          input logic [6:0] fp, input logic [7:0] fd,
                                          input logic [31:0] cy);
    logic [31:0] r;
    r = 32'h0;
    if (is_reg(a, `ABOE_OFS_INSN)) r = iw;
    if (is_reg(a, `ABOE_OFS_ACC)) r = {24'h0, acc};
    if (is_reg(a, `ABOE_OFS_STATUS)) r = sw;
    if (is_reg(a, `ABOE_OFS_FPTR)) r = {25'h0, fp};
    if (is_reg(a, `ABOE_OFS_FDATA)) r = {24'h0, fd};
    if (is_reg(a, `ABOE_OFS_CYCLES)) r = cy;
    return r;
  endfunction

  // write decode: state touched by execution is locked while pending,
  // which keeps software and the core from ever writing the same state in one cycle
  wire logic wr_go, wr_lock, wr_err, wr_ok;
  wire logic [31:0] wr_word;
  wire logic wr_insn, wr_acc, wr_stat, wr_fptr, wr_fdata;
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lock = pending_reg && !is_reg(aw_addr_reg, `ABOE_OFS_FPTR);
  assign wr_err = !is_mapped(aw_addr_reg) || wr_lock || is_reg(aw_addr_reg, `ABOE_OFS_CYCLES);
  assign wr_ok = wr_go && !wr_err;
  assign wr_word = merge_strb(word_at(aw_addr_reg, insn_word, stat_word, acc_reg, fptr_reg,
                                      file_b, cycles_reg), w_data_reg, w_strb_reg);
  assign wr_insn = wr_ok && is_reg(aw_addr_reg, `ABOE_OFS_INSN);
  assign wr_acc = wr_ok && is_reg(aw_addr_reg, `ABOE_OFS_ACC);
  assign wr_stat = wr_ok && is_reg(aw_addr_reg, `ABOE_OFS_STATUS);
  assign wr_fptr = wr_ok && is_reg(aw_addr_reg, `ABOE_OFS_FPTR);
  assign wr_fdata = wr_ok && is_reg(aw_addr_reg, `ABOE_OFS_FDATA);

  // file write port: the core's result, else a software data write
  wire logic rf_we;
  wire logic [6:0] rf_waddr;
  wire logic [7:0] rf_wdata;
  assign rf_we = (do_op && alu_file_we) || wr_fdata;
  assign rf_waddr = do_op ? faddr_reg : fptr_reg;
  assign rf_wdata = do_op ? alu_result : wr_word[7:0];

  aboe_alu u_alu (
    .op_in(op_cur),
    .dest_in(dest_reg),
    .bit_in(bit_reg),
    .imm_in(imm_reg),
    .acc_in(acc_reg),
    .file_in(file_a),
    .result_out(alu_result),
    .carry_out(alu_carry),
    .nibble_out(alu_nibble),
    .zero_out(alu_zero),
    .acc_we_out(alu_acc_we),
    .file_we_out(alu_file_we),
    .flag_we_out(alu_flag_we),
    .skip_out(alu_skip)
  );

  aboe_regfile #(.DEPTH(128), .AW(7), .PORT_ADDR(PORT_ADDR)) u_file (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .we_in(rf_we),
    .waddr_in(rf_waddr),
    .wdata_in(rf_wdata),
    .exec_addr_in(faddr_reg),
    .sw_addr_in(fptr_reg),
    .pins_in(pin_sync_reg),
    .exec_data_out(file_a),
    .sw_data_out(file_b),
    .latch_out(PORT_LATCH_OUT)
  );

  // instruction cycle divider and pin synchroniser
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      tcnt_reg <= 8'h00;
      tick_reg <= 1'b0;
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      tcnt_reg <= (tcnt_reg == 8'(TCY_CLKS - 1)) ? 8'h00 : tcnt_reg + 8'h01;
      tick_reg <= (tcnt_reg == 8'(TCY_CLKS - 1));
      pin_meta_reg <= PORT_PINS_IN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // instruction issue, skip bookkeeping and cycle count
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      op_raw_reg <= 4'h0;
      dest_reg <= `ABOE_DEST_FILE;
      bit_reg <= 3'h0;
      faddr_reg <= 7'h00;
      imm_reg <= 8'h00;
      pending_reg <= 1'b0;
      skip_armed_reg <= 1'b0;
      discard_reg <= 1'b0;
      cycles_reg <= 32'h0;
    end else begin
      if (wr_insn) begin
        op_raw_reg <= wr_word[`ABOE_INSN_OP_LSB +: 4];
        dest_reg <= wr_word[`ABOE_INSN_DEST_POS];
        bit_reg <= wr_word[`ABOE_INSN_BIT_LSB +: 3];
        faddr_reg <= wr_word[`ABOE_INSN_FILE_LSB +: 7];
        imm_reg <= wr_word[`ABOE_INSN_IMM_LSB +: 8];
        pending_reg <= 1'b1;
      end else if (exec) begin
        pending_reg <= 1'b0;
      end
      if (exec) begin
        // a taken skip turns the following instruction into an idle slot
        skip_armed_reg <= do_op && alu_skip;
        discard_reg <= skip_armed_reg;
        cycles_reg <= cycles_reg + 32'h1;
      end
    end
  end

  // accumulator and flags; only listed flags move
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      acc_reg <= `ABOE_ACC_RST;
      carry_reg <= 1'b0;
      nibble_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (do_op) begin
      if (alu_acc_we) acc_reg <= alu_result;
      if (alu_flag_we[0]) carry_reg <= alu_carry;
      if (alu_flag_we[1]) nibble_reg <= alu_nibble;
      if (alu_flag_we[2]) zero_reg <= alu_zero;
    end else begin
      if (wr_acc) acc_reg <= wr_word[7:0];
      if (wr_stat) carry_reg <= wr_word[`ABOE_STAT_CARRY];
      if (wr_stat) nibble_reg <= wr_word[`ABOE_STAT_NIBBLE];
      if (wr_stat) zero_reg <= wr_word[`ABOE_STAT_ZERO];
    end
  end

  // software file pointer
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      fptr_reg <= 7'h00;
    end else if (wr_fptr) begin
      fptr_reg <= wr_word[6:0];
    end
  end

  // axi write channels: address and data held independently
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ABOE_RESP_OKAY;
    end else begin
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= AXI_AWADDR_IN;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
        w_held_reg <= 1'b1;
        w_data_reg <= AXI_WDATA_IN;
        w_strb_reg <= AXI_WSTRB_IN;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_err ? `ABOE_RESP_SLVERR : `ABOE_RESP_OKAY;
      end else if (AXI_BREADY_IN) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // axi read: one outstanding, data captured on acceptance
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `ABOE_RESP_OKAY;
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= word_at(AXI_ARADDR_IN, insn_word, stat_word, acc_reg, fptr_reg,
                           file_b, cycles_reg);
      rresp_reg <= is_mapped(AXI_ARADDR_IN) ? `ABOE_RESP_OKAY : `ABOE_RESP_SLVERR;
    end else if (AXI_RREADY_IN) begin
      rvalid_reg <= 1'b0;
    end
  end

  // handshake outputs
  assign AXI_AWREADY_OUT = !aw_held_reg && !bvalid_reg;
  assign AXI_WREADY_OUT = !w_held_reg && !bvalid_reg;
  assign AXI_BVALID_OUT = bvalid_reg;
  assign AXI_BRESP_OUT = bresp_reg;
  assign AXI_ARREADY_OUT = !rvalid_reg;
  assign AXI_RVALID_OUT = rvalid_reg;
  assign AXI_RDATA_OUT = rdata_reg;
  assign AXI_RRESP_OUT = rresp_reg;
  assign ACC_OUT = acc_reg;
  assign BUSY_OUT = pending_reg;

  // helper values for the checks below
  wire logic [8:0] chk_sum9;
  wire logic [4:0] chk_sum5;
  wire logic tested_bit;
  wire logic [7:0] chk_pin_sum;
  assign chk_sum9 = {1'b0, acc_reg} + {1'b0, imm_reg};
  assign chk_sum5 = {1'b0, acc_reg[3:0]} + {1'b0, imm_reg[3:0]};
  assign tested_bit = file_a[bit_reg];
  assign chk_pin_sum = acc_reg + pin_sync_reg;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  acc_sum_imm_a :
  assert property ((do_op && op_cur == aboe_pkg::sum_immediate_into_acc)
    |=> acc_reg == 8'($past(acc_reg) + $past(imm_reg)))
    else $error("immediate sum not in accumulator");
  sum_flags_a :
  assert property ((do_op && op_cur == aboe_pkg::sum_immediate_into_acc)
    |=> carry_reg == $past(chk_sum9[8]) && nibble_reg == $past(chk_sum5[4]) &&
        zero_reg == (acc_reg == 8'h00))
    else $error("sum flags wrong");
  reg_sum_file_a :
  assert property ((do_op && op_cur == aboe_pkg::sum_acc_with_register && dest_reg)
    |=> $stable(acc_reg) && zero_reg == ($past(alu_result) == 8'h00))
    else $error("register sum to file touched accumulator");
  pin_read_a :
  assert property ((do_op && op_cur == aboe_pkg::sum_acc_with_register && !dest_reg &&
                    faddr_reg == PORT_ADDR) |=> acc_reg == $past(chk_pin_sum))
    else $error("port operand not taken from pins");
  mask_imm_flags_a :
  assert property ((do_op && op_cur == aboe_pkg::mask_acc_with_immediate)
    |=> $stable(carry_reg) && $stable(nibble_reg) && zero_reg == (acc_reg == 8'h00))
    else $error("immediate mask flags wrong");
  mask_reg_acc_a :
  assert property ((do_op && op_cur == aboe_pkg::mask_acc_with_register && !dest_reg)
    |=> acc_reg == ($past(acc_reg) & $past(file_a)) && $stable(carry_reg))
    else $error("register mask result wrong");
  bit_ops_flags_a :
  assert property ((do_op && (op_cur == aboe_pkg::single_bit_clear ||
                              op_cur == aboe_pkg::single_bit_raise))
    |=> $stable(carry_reg) && $stable(nibble_reg) && $stable(zero_reg) && $stable(acc_reg))
    else $error("bit operation changed flags");
  skip_one_a :
  assert property ((do_op && op_cur == aboe_pkg::test_skip_when_one)
    |=> skip_armed_reg == $past(tested_bit) && $stable(zero_reg))
    else $error("skip when one wrong");
  skip_zero_a :
  assert property ((do_op && op_cur == aboe_pkg::test_skip_when_zero)
    |=> skip_armed_reg == !$past(tested_bit) && $stable(carry_reg))
    else $error("skip when zero wrong");
  idle_slot_a :
  assert property ((exec && skip_armed_reg)
    |=> !skip_armed_reg && discard_reg && !pending_reg && $stable(acc_reg) &&
        cycles_reg == $past(cycles_reg) + 32'h1)
    else $error("discarded instruction was not an idle slot");
endmodule // aboe_top
